// ===== verilog/odsc_pkg.sv
// shared constants, register map and divide table for the output divider control
package odsc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DIV    = 8'h04;
    localparam logic [7:0] ADDR_OUT    = 8'h08;
    localparam logic [7:0] ADDR_TIMING = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // control register bit positions
    localparam int CTRL_POWERDOWN  = 0;
    localparam int CTRL_FCAL       = 1;
    localparam int CTRL_SYNC_EN    = 2;
    localparam int CTRL_FRAC       = 3;
    // output register field positions
    localparam int OUT_A_SRC_LSB   = 0;
    localparam int OUT_B_SRC_LSB   = 2;
    localparam int OUT_A_PWR_LSB   = 4;
    localparam int OUT_B_PWR_LSB   = 10;
    // output source encodings
    localparam logic [1:0] SRC_CHAN_DIV_SELECT  = 2'h0;
    localparam logic [1:0] SRC_VCO    = 2'h1;
    localparam logic [1:0] SRC_SYSTEM_REFERENCE_PATH = 2'h2;
    // reset values
    localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RST_DIV    = 32'h0000_0000;
    localparam logic [31:0] RST_OUT    = 32'h0000_0005;
    localparam logic [31:0] RST_TIMING = 32'h0040_0010;
    // power step codes: 32..47 fold onto 31
    localparam logic [5:0] PWR_DUP_LO = 6'h20;
    localparam logic [5:0] PWR_DUP_HI = 6'h2f;
    localparam logic [5:0] PWR_TOP_LO = 6'h1f;
    // calibration time and the derived cycle count at 25 MHz (40 ns)
    localparam int CLK_PERIOD_NS = 40;
    localparam int CAL_TIME_NS   = 10000;
    localparam logic [15:0] CAL_CYCLES =
        16'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] LAST_VALID_SEL = 5'h0d;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        SY_IDLE   = 3'b000,
        SY_RETIME = 3'b001,
        SY_CAL    = 3'b010,
        SY_SETTLE = 3'b011,
        SY_MASH   = 3'b100,
        SY_DONE   = 3'b101
    } odsc_sync_t;

    // {seg_a, seg_b, seg_c, seg_d, total}; zero for codes with no division
    function automatic logic [23:0] odsc_decode(input logic [4:0] sel);
        case (sel)
            5'h00:   odsc_decode = {4'h2, 4'h1, 4'h1, 4'h1, 8'h02};
            5'h01:   odsc_decode = {4'h2, 4'h2, 4'h1, 4'h1, 8'h04};
            5'h02:   odsc_decode = {4'h2, 4'h3, 4'h1, 4'h1, 8'h06};
            5'h03:   odsc_decode = {4'h2, 4'h2, 4'h2, 4'h1, 8'h08};
            5'h04:   odsc_decode = {4'h2, 4'h3, 4'h2, 4'h1, 8'h0c};
            5'h05:   odsc_decode = {4'h2, 4'h2, 4'h4, 4'h1, 8'h10};
            5'h06:   odsc_decode = {4'h2, 4'h3, 4'h4, 4'h1, 8'h18};
            5'h07:   odsc_decode = {4'h2, 4'h2, 4'h8, 4'h1, 8'h20};
            5'h08:   odsc_decode = {4'h2, 4'h3, 4'h8, 4'h1, 8'h30};
            5'h09:   odsc_decode = {4'h2, 4'h2, 4'h8, 4'h2, 8'h40};
            5'h0a:   odsc_decode = {4'h2, 4'h3, 4'h6, 4'h2, 8'h48};
            5'h0b:   odsc_decode = {4'h2, 4'h3, 4'h8, 4'h2, 8'h60};
            5'h0c:   odsc_decode = {4'h2, 4'h2, 4'h8, 4'h4, 8'h80};
            5'h0d:   odsc_decode = {4'h2, 4'h3, 4'h8, 4'h4, 8'hc0};
            default: odsc_decode = 24'h00_0000;
        endcase
    endfunction : odsc_decode
endpackage : odsc_pkg

// ===== verilog/odsc_segment.sv
// one modulo counter of the cascaded channel divider
`timescale 1ns/10ps
module odsc_segment
    import odsc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       advance,
    input  wire logic [3:0] div_value,
    output logic            wrap
);
    logic [3:0] count;
    wire        at_top = (count >= div_value - 4'h1);

    // wrap fires on the advance that closes one full period of this stage
    assign wrap = advance && at_top && (div_value != 4'h0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || div_value == 4'h0)
            count <= 4'h0;
        else if (wrap)
            count <= 4'h0;
        else if (advance)
            count <= count + 4'h1;
    end
endmodule : odsc_segment

// ===== verilog/odsc_top.sv
// output divider, power gating, powerdown and phase sync control with an AXI4-Lite slave
//Contract
// - total divide is product of four segments
// - codes 0..6 decode to divides 2..24
// - divider powered when outputs select it
// - power codes 32..47 duplicate, next is 48
// - pin or bit enters and leaves powerdown
// - sync retimed to next reference rising edge
// - phase deterministic after cal, settle, modulator count
// - feedback extra divide chosen 1, 6 or 4
// - software 0 to 1 sync bit is request
// - calibration starts on write with trigger set
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module odsc_top
    import odsc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        reference_input,
    input  wire logic        sync_pin,
    input  wire logic        cal_pin_n,
    output logic             chan_div_pulse,
    output logic             divider_powered,
    output logic             device_powered_down,
    output logic             cal_busy,
    output logic             phase_deterministic,
    output logic [2:0]       feedback_extra_divide,
    output logic [5:0]       output_a_power_level,
    output logic [5:0]       output_b_power_level
);
    logic [31:0] ctrl_reg, div_reg, out_reg, timing_reg;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_full, w_full;
    logic [2:0]  ref_sync, pin_sync, cal_sync;
    logic        sync_pending, need_recal;
    logic [15:0] cal_count, wait_count;
    odsc_sync_t  sync_state, next_sync_state;
    logic [3:0]  segment_a_value, segment_b_value, segment_c_value, segment_d_value;
    logic [7:0]  total_div;
    logic        div_invalid;

    // write channel: address and data are held separately, so either may come first
    wire do_write = aw_full && w_full && !s_axi_bvalid;
    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    wire [7:0] wr_word = {aw_addr[7:2], 2'b00};
    wire wr_ctrl   = do_write && wr_word == ADDR_CTRL;
    wire wr_div    = do_write && wr_word == ADDR_DIV;
    wire wr_out    = do_write && wr_word == ADDR_OUT;
    wire wr_timing = do_write && wr_word == ADDR_TIMING;
    wire wr_hit    = wr_ctrl || wr_div || wr_out || wr_timing || wr_word == ADDR_STATUS;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] ctrl_new = (ctrl_reg & ~wmask) | (w_data & wmask);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_full <= 1'b0;
            if (s_axi_wvalid && !w_full)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_full <= 1'b0;
        end
    end

    // write response; status writes are accepted and ignored, unmapped gets SLVERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // configuration registers with byte strobes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg   <= RST_CTRL;
            div_reg    <= RST_DIV;
            out_reg    <= RST_OUT;
            timing_reg <= RST_TIMING;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= ctrl_new & 32'h0000_000d;   // trigger bit is write-only
            if (wr_div)
                div_reg <= ((div_reg & ~wmask) | (w_data & wmask)) & 32'h0000_001f;
            if (wr_out)
                out_reg <= ((out_reg & ~wmask) | (w_data & wmask)) & 32'h0000_ffff;
            if (wr_timing)
                timing_reg <= (timing_reg & ~wmask) | (w_data & wmask);
        end
    end

    // read channel, single outstanding read
    wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] status_word = {
        7'h00, total_div, segment_d_value, segment_c_value,
        feedback_extra_divide, div_invalid, need_recal, phase_deterministic,
        cal_busy, device_powered_down, divider_powered};
    wire rd_hit = rd_word inside {ADDR_CTRL, ADDR_DIV, ADDR_OUT, ADDR_TIMING, ADDR_STATUS};
    wire [31:0] rd_mux = rd_word == ADDR_CTRL   ? ctrl_reg   :
                         rd_word == ADDR_DIV    ? div_reg    :
                         rd_word == ADDR_OUT    ? out_reg    :
                         rd_word == ADDR_TIMING ? timing_reg :
                         rd_word == ADDR_STATUS ? status_word : 32'h0000_0000;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // pins: two flops before use, third flop only for edge detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_sync <= 3'h0;
            pin_sync <= 3'h0;
            cal_sync <= 3'h7;
        end
        else
        begin
            ref_sync <= {ref_sync[1:0], reference_input};
            pin_sync <= {pin_sync[1:0], sync_pin};
            cal_sync <= {cal_sync[1:0], cal_pin_n};
        end
    end

    wire ref_rise  = ref_sync[1] && !ref_sync[2];
    wire sync_en   = ctrl_reg[CTRL_SYNC_EN];
    wire pin_rise  = pin_sync[1] && !pin_sync[2] && sync_en;
    wire sw_rise   = wr_ctrl && ctrl_new[CTRL_SYNC_EN] && !sync_en;
    wire sync_req  = pin_rise || sw_rise;
    wire pd_now    = ctrl_reg[CTRL_POWERDOWN] || !cal_sync[1];
    wire cal_start = wr_ctrl && w_data[CTRL_FCAL] && w_strb[0] && !pd_now;
    wire sync_cal  = sync_state == SY_RETIME && ref_rise;

    // powerdown state; leaving it flags that a recalibration is owed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            device_powered_down <= 1'b0;
            need_recal          <= 1'b0;
        end
        else
        begin
            device_powered_down <= pd_now;
            if (device_powered_down && !pd_now)
                need_recal <= 1'b1;
            else if (cal_start)
                need_recal <= 1'b0;
        end
    end

    // frequency calibration timer; a new trigger restarts it, powerdown aborts it
    always_ff @(posedge aclk)
    begin
        if (!aresetn || pd_now)
        begin
            cal_busy  <= 1'b0;
            cal_count <= 16'h0000;
        end
        else if (cal_start || sync_cal)
        begin
            cal_busy  <= 1'b1;
            cal_count <= CAL_CYCLES;
        end
        else if (cal_busy)
        begin
            cal_count <= cal_count - 16'h0001;
            cal_busy  <= cal_count != 16'h0001;
        end
    end

    // sync sequencer: retime, calibrate, settle, modulator count
    always_comb
    begin
        next_sync_state = sync_state;
        case (sync_state)
            SY_IDLE, SY_DONE:
                if (sync_pending && !pd_now)
                    next_sync_state = SY_RETIME;
            SY_RETIME:
                if (ref_rise)
                    next_sync_state = SY_CAL;
            SY_CAL:
                if (!cal_busy)
                    next_sync_state = SY_SETTLE;
            SY_SETTLE:
                if (wait_count == 16'h0000)
                    next_sync_state = ctrl_reg[CTRL_FRAC] ? SY_MASH : SY_DONE;
            SY_MASH:
                if (wait_count == 16'h0000)
                    next_sync_state = SY_DONE;
            default:
                next_sync_state = SY_IDLE;
        endcase
        if (pd_now)
            next_sync_state = SY_IDLE;
    end

    // the pending flag is set-dominant so a request in the launch cycle survives
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_state   <= SY_IDLE;
            sync_pending <= 1'b0;
            wait_count   <= 16'h0000;
        end
        else
        begin
            sync_state <= next_sync_state;
            if (sync_req)
                sync_pending <= 1'b1;
            else if (next_sync_state == SY_RETIME && sync_state != SY_RETIME)
                sync_pending <= 1'b0;
            if (sync_state == SY_CAL)
                wait_count <= timing_reg[31:16];
            else if (sync_state == SY_SETTLE && wait_count == 16'h0000)
                wait_count <= timing_reg[15:0];
            else if (wait_count != 16'h0000)
                wait_count <= wait_count - 16'h0001;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phase_deterministic <= 1'b0;
        else
            phase_deterministic <= next_sync_state == SY_DONE && !sync_pending;
    end

    // divider power and source-derived settings
    wire [1:0] src_a = out_reg[OUT_A_SRC_LSB +: 2];
    wire [1:0] src_b = out_reg[OUT_B_SRC_LSB +: 2];
    wire div_on = !pd_now &&
                  (src_a == SRC_CHAN_DIV_SELECT || src_b == SRC_CHAN_DIV_SELECT || src_b == SRC_SYSTEM_REFERENCE_PATH);
    wire [5:0] pwr_a = out_reg[OUT_A_PWR_LSB +: 6];
    wire [5:0] pwr_b = out_reg[OUT_B_PWR_LSB +: 6];
    wire a_dup = pwr_a >= PWR_DUP_LO && pwr_a <= PWR_DUP_HI;
    wire b_dup = pwr_b >= PWR_DUP_LO && pwr_b <= PWR_DUP_HI;
    wire by3   = total_div % 8'h03 == 8'h00 && total_div != 8'h18 && total_div != 8'hc0;
    wire [2:0] next_extra = (!sync_en || (src_a == SRC_VCO && src_b == SRC_VCO)) ? 3'h1 :
                            by3 ? 3'h6 : 3'h4;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            divider_powered       <= 1'b0;
            feedback_extra_divide <= 3'h1;
            output_a_power_level  <= 6'h00;
            output_b_power_level  <= 6'h00;
        end
        else
        begin
            divider_powered       <= div_on;
            feedback_extra_divide <= next_extra;
            output_a_power_level  <= a_dup ? PWR_TOP_LO : pwr_a;
            output_b_power_level  <= b_dup ? PWR_TOP_LO : pwr_b;
        end
    end

    // cascaded segments; the first stage advances every cycle while powered and valid, each later stage on the previous stage's wrap
    logic [3:0] seg_val [4];
    logic [4:0] adv;
    assign seg_val[0] = segment_a_value;
    assign seg_val[1] = segment_b_value;
    assign seg_val[2] = segment_c_value;
    assign seg_val[3] = segment_d_value;
    assign adv[0]     = divider_powered && !div_invalid;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_seg
            odsc_segment u_seg (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .advance   (adv[gi]),
                .div_value (seg_val[gi]),
                .wrap      (adv[gi + 1])
            );
        end
    endgenerate

    // divide values reload only at a full-period boundary or while the chain is stopped (unpowered or invalid code)
    wire [23:0] dec      = odsc_decode(div_reg[4:0]);
    wire        sel_new  = dec != {segment_a_value, segment_b_value,
                                   segment_c_value, segment_d_value, total_div};
    wire        div_idle = !adv[0] || adv[4];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {segment_a_value, segment_b_value, segment_c_value,
             segment_d_value, total_div} <= 24'h00_0000;
            div_invalid    <= 1'b1;
            chan_div_pulse <= 1'b0;
        end
        else
        begin
            if (sel_new && div_idle)
            begin
                {segment_a_value, segment_b_value, segment_c_value,
                 segment_d_value, total_div} <= dec;
                div_invalid <= div_reg[4:0] > LAST_VALID_SEL;
            end
            chan_div_pulse <= adv[4];
        end
    end
endmodule : odsc_top

// ===== bench/odsc_checker.sv
// port checks for the output divider control block
`timescale 1ns/10ps
module odsc_checker
    import odsc_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       cal_pin_n,
    input wire logic       chan_div_pulse,
    input wire logic       divider_powered,
    input wire logic       device_powered_down,
    input wire logic       cal_busy,
    input wire logic [2:0] feedback_extra_divide,
    input wire logic [5:0] output_a_power_level
);
    // single clock domain, so one default clock and reset serve all checks
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    pulse_gap_a: assert property (chan_div_pulse |=> !chan_div_pulse)
        else $error("divider pulses too close");
    extra_div_a: assert property (feedback_extra_divide inside {3'h1, 3'h4, 3'h6})
        else $error("feedback divide out of set");
    pwr_fold_a: assert property (!(output_a_power_level inside {[6'h20:6'h2f]}))
        else $error("duplicate power step seen");
    pd_gate_a: assert property (device_powered_down [*2] |-> !divider_powered)
        else $error("divider on in powerdown");
    pin_pd_a: assert property (!cal_pin_n [*5] |-> device_powered_down)
        else $error("cal pin low, still powered");
    // powerdown may cut a calibration short; anything else must let it run for at least 8 cycles
    cal_run_a: assert property ($rose(cal_busy) |-> (cal_busy || device_powered_down) [*8])
        else $error("calibration cut short");
endmodule : odsc_checker

bind odsc_top odsc_checker odsc_checker_inst
(
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
    .cal_pin_n, .chan_div_pulse, .divider_powered, .device_powered_down, .cal_busy,
    .feedback_extra_divide, .output_a_power_level
);

// ===== bench/odsc_ref_osc.sv
// reference oscillator model that stands still while not running
`timescale 1ns/10ps
module odsc_ref_osc
(
    input  wire logic aclk,
    input  wire logic run,
    output logic      reference_input
);
    logic half = 1'b0;
    logic level = 1'b0;

    // four aclk periods per cycle, far below the 40 MHz ceiling
    always @(posedge aclk)
    begin
        half <= run && !half;
        level <= level ^ (run && half);
    end
    assign reference_input = level;
endmodule : odsc_ref_osc

// ===== bench/testbench.sv
// self-checking bench for the output divider control block
`timescale 1ns/10ps
module testbench
    import odsc_pkg::*;
;
    logic        aclk, aresetn, sync_pin, ref_run, cal_pin_n, reference_input;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        chan_div_pulse, divider_powered, device_powered_down, cal_busy;
    logic        phase_deterministic;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [2:0]  feedback_extra_divide;
    logic [5:0]  output_a_power_level, output_b_power_level;
    logic [27:0] e;
    int          p, err_total, n_checks;
    // out select, powered, total, seg c, seg d, feedback divide; last two reuse code 0
    logic [27:0] rows [16] = '{28'h4102114, 28'h1104114, 28'h9106116, 28'h4108214,
        28'h410c216, 28'h4110414, 28'h4118414, 28'h4120814, 28'h4130816, 28'h4140824,
        28'h4148626, 28'h4160826, 28'h4180844, 28'h41c0844, 28'h5002111, 28'h6002114};

    // 25 MHz clock
    always #20 aclk = !aclk;

    odsc_top odsc_top_inst
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reference_input, .sync_pin,
        .cal_pin_n, .chan_div_pulse, .divider_powered, .device_powered_down, .cal_busy,
        .phase_deterministic, .feedback_extra_divide, .output_a_power_level,
        .output_b_power_level
    );
    odsc_ref_osc odsc_ref_osc_inst (.aclk, .run(ref_run), .reference_input);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic hang_stop();
        err_total++;
        report_and_stop();
    endtask : hang_stop

    // one access; sampling at the falling edge avoids racing the ready logic
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tr, tb;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        tb = 1'b0;
        for (int n = 0; n < 99 && !tb; n++)
        begin
            @(negedge aclk);
            {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
            tb = w ? s_axi_bvalid : s_axi_rvalid;
            {r, d} = {w ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tr)
                s_axi_arvalid <= 1'b0;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (!tb)
            hang_stop();
    endtask : bus

    // bounded wait for phase (sel 0) or powerdown (sel 1) to reach a level
    task automatic wait_for(input int sel, input logic lvl);
        for (int n = 0; n < 1000; n++)
        begin
            @(negedge aclk);
            if ((sel == 0 ? phase_deterministic : device_powered_down) === lvl)
                return;
        end
        hang_stop();
    endtask : wait_for

    // gap between second and third pulse, so a pending reload is already done
    task automatic period();
        int seen, last;
        {seen, last} = '0;
        for (int k = 0; k < 1000 && seen < 3; k++)
        begin
            @(negedge aclk);
            if (chan_div_pulse)
                {seen, p, last} = {seen + 1, k - last, k};
        end
        if (seen < 3)
            hang_stop();
    endtask : period

    // reset, the divide table, then the awkward cases
    initial
    begin
        {aclk, aresetn, sync_pin, ref_run, cal_pin_n} = 5'b00001;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {err_total, n_checks} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, ADDR_OUT, 0);
        check(d, RST_OUT);
        check(r, RESP_OKAY);
        bus(0, ADDR_STATUS, 0);
        check(d[8:0], 9'h040);
        $display("reset test done");
        bus(1, ADDR_CTRL, 32'h4); // software request with the reference stopped
        for (int i = 0; i < 16; i++)
        begin
            e = rows[i];
            bus(1, ADDR_OUT, {28'h0, e[27:24]}); // spare output left on the VCO
            bus(1, ADDR_DIV, (i > 13) ? 32'h0 : 32'(i)); // defined codes only
            if (e[20])
                period();
            if (e[20])
                check(p, e[19:12]);
            bus(0, ADDR_STATUS, 0);
            check(d[24:6], {e[19:12], e[7:4], e[11:8], e[2:0]});
            check({divider_powered, d[0]}, {2{e[20]}});
            $display("row %0d done", i);
        end
        check(phase_deterministic, 1'b0);
        ref_run <= 1'b1;
        wait_for(0, 1'b1);
        bus(1, ADDR_DIV, 32'he); // a code with no division
        bus(0, ADDR_STATUS, 0);
        check({d[24:17], d[5]}, 9'h001);
        bus(1, ADDR_OUT, 32'h7ef5);
        @(negedge aclk); // power levels register on the edge that ends the write
        check({output_a_power_level, output_b_power_level}, 12'h7df);
        bus(1, ADDR_OUT, 32'h8305);
        @(negedge aclk);
        check({output_a_power_level, output_b_power_level}, 12'hc1f);
        bus(1, 8'h20, 32'hffff_ffff);
        check(r, RESP_SLVERR);
        $display("sync, power and map tests done");
        bus(1, ADDR_DIV, 32'h0);
        bus(1, ADDR_OUT, 32'h4);
        bus(1, ADDR_CTRL, 32'h5);
        repeat (3) @(negedge aclk);
        check({device_powered_down, divider_powered, phase_deterministic}, 3'h4);
        bus(1, ADDR_CTRL, 32'h4);
        bus(0, ADDR_STATUS, 0);
        check(d[4], 1'b1);
        bus(1, ADDR_CTRL, 32'h6); // host recalibrates
        bus(0, ADDR_STATUS, 0);
        check(d[4:2], 3'b001);
        @(posedge aclk);
        cal_pin_n <= 1'b0;
        wait_for(1, 1'b1);
        repeat (6) @(posedge aclk);
        cal_pin_n <= 1'b1;
        wait_for(1, 1'b0);
        bus(1, ADDR_CTRL, 32'hc); // fractional mode, sync still enabled
        check(phase_deterministic, 1'b0);
        sync_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        sync_pin <= 1'b0;
        wait_for(0, 1'b1);
        $display("powerdown and pin tests done");
        report_and_stop();
    end
endmodule : testbench
